// ==== hw/cafr_pkg.sv ====
// Package: register map, field layout and reset values of the filter routing bank
package cafr_pkg;
	localparam int          ADDR_W        = 4;
	localparam int          DATA_W        = 32;
	localparam int          NUM_FILT      = 8;
	localparam int          FIRST_FILT    = 16;
	localparam int          MSEL_W        = 2;
	localparam int          FSEL_W        = 5;
	localparam int          SLOT_W        = 8;
	localparam int          SLOTS_PER_REG = 4;
	// Byte address of each control word
	localparam logic [3:0]  OFS_CTRL_FOUR = 4'h0;
	localparam logic [3:0]  OFS_CTRL_FIVE = 4'h4;
	// Field positions inside one byte slot
	localparam int          POS_ON        = 7;
	localparam int          POS_MSEL      = 5;
	localparam int          POS_FSEL      = 0;
	localparam logic [7:0]  SLOT_RST      = 8'h00;
	localparam logic [31:0] RD_UNMAPPED   = 32'h00000000;
endpackage : cafr_pkg

// ==== hw/cafr_slot_if.sv ====
// Interface: per-filter configuration carried from the register slots to the routing outputs
`timescale 1ns/1ns
`default_nettype none
interface cafr_slot_if;
	import cafr_pkg::*;
	logic [NUM_FILT-1:0]        on;
	logic [NUM_FILT*MSEL_W-1:0] msel;
	logic [NUM_FILT*FSEL_W-1:0] fsel;
	modport src (output on, output msel, output fsel);
	modport dst (input on, input msel, input fsel);
endinterface : cafr_slot_if
`default_nettype wire

// ==== hw/cafr_slot.sv ====
// One filter's control byte: enable, mask select and FIFO destination with write lock
`timescale 1ns/1ns
`default_nettype none
module cafr_slot
	import cafr_pkg::*;
(
	input  wire logic                    i_clk,
	input  wire logic                    i_rst,
	input  wire logic                    i_wr,
	input  wire logic [SLOT_W-1:0]       i_wdata,
	output logic                         o_on,
	output logic [MSEL_W-1:0]            o_msel,
	output logic [FSEL_W-1:0]            o_fsel
);
	logic                 on_ff;
	logic [MSEL_W-1:0]    msel_ff;
	logic [FSEL_W-1:0]    fsel_ff;

	// Enable bit is always writable so software can switch the filter off
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			on_ff <= SLOT_RST[POS_ON];
		end else if (i_wr) begin
			on_ff <= i_wdata[POS_ON];
		end
	end

	// Routing fields move only while the stored enable is low, so a live filter never sees them change
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			msel_ff <= SLOT_RST[POS_MSEL +: MSEL_W];
			fsel_ff <= SLOT_RST[POS_FSEL +: FSEL_W];
		end else if (i_wr && !on_ff) begin
			msel_ff <= i_wdata[POS_MSEL +: MSEL_W];
			fsel_ff <= i_wdata[POS_FSEL +: FSEL_W];
		end
	end

	assign o_on   = on_ff;
	assign o_msel = msel_ff;
	assign o_fsel = fsel_ff;
endmodule : cafr_slot
`default_nettype wire

// ==== hw/cafr_top.sv ====
// Top: register port and routing outputs of the eight acceptance filters 16 to 23
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module cafr_top
	import cafr_pkg::*;
(
	input  wire logic                          I_CLOCK,
	input  wire logic                          I_SYS_RST,
	input  wire logic [cafr_pkg::ADDR_W-1:0]   I_ADDR,
	input  wire logic [cafr_pkg::DATA_W-1:0]   I_WDATA,
	input  wire logic                          I_WR,
	input  wire logic                          I_RD,
	input  wire logic [cafr_pkg::NUM_FILT-1:0] I_HIT,
	output logic      [cafr_pkg::DATA_W-1:0]   O_RDATA,
	output logic      [cafr_pkg::NUM_FILT-1:0] O_FILT_ON,
	output logic      [cafr_pkg::NUM_FILT*cafr_pkg::MSEL_W-1:0] O_MASK_PICK,
	output logic      [cafr_pkg::NUM_FILT*cafr_pkg::FSEL_W-1:0] O_FIFO_DEST,
	output logic                               O_ROUTE_VALID,
	output logic      [cafr_pkg::FSEL_W-1:0]   O_ROUTE_FIFO
);
	import cafr_pkg::*;

	cafr_slot_if          cfg ();
	logic                 sel_four;
	logic                 sel_five;
	logic [DATA_W-1:0]    word_four;
	logic [DATA_W-1:0]    word_five;
	logic [DATA_W-1:0]    rdata_ff;
	logic [DATA_W-1:0]    nxt_rdata;
	logic [NUM_FILT-1:0]              on_ff;
	logic [NUM_FILT*MSEL_W-1:0]       msel_ff;
	logic [NUM_FILT*FSEL_W-1:0]       fsel_ff;
	logic                 route_valid_ff;
	logic [FSEL_W-1:0]    route_fifo_ff;
	logic                 nxt_route_valid;
	logic [FSEL_W-1:0]    nxt_route_fifo;

	// Address decode; every other address reads zero and ignores writes
	assign sel_four = (I_ADDR == OFS_CTRL_FOUR);
	assign sel_five = (I_ADDR == OFS_CTRL_FIVE);

	// Slot k sits in word four for filters 16-19, word five for 20-23, byte k mod 4
	for (genvar k = 0; k < NUM_FILT; k++) begin : g_slot
		localparam int LANE = k % SLOTS_PER_REG;
		logic          wr_slot;
		logic [SLOT_W-1:0] wbyte;
		logic [SLOT_W-1:0] rbyte;
		assign wr_slot = I_WR && ((k < SLOTS_PER_REG) ? sel_four : sel_five);
		assign wbyte   = I_WDATA[LANE*SLOT_W +: SLOT_W];
		cafr_slot u_slot (
			.i_clk   (I_CLOCK),
			.i_rst   (I_SYS_RST),
			.i_wr    (wr_slot),
			.i_wdata (wbyte),
			.o_on    (cfg.on[k]),
			.o_msel  (cfg.msel[k*MSEL_W +: MSEL_W]),
			.o_fsel  (cfg.fsel[k*FSEL_W +: FSEL_W])
		);
		assign rbyte = {cfg.on[k], cfg.msel[k*MSEL_W +: MSEL_W], cfg.fsel[k*FSEL_W +: FSEL_W]};
		if (k < SLOTS_PER_REG) begin : g_four
			assign word_four[LANE*SLOT_W +: SLOT_W] = rbyte;
		end else begin : g_five
			assign word_five[LANE*SLOT_W +: SLOT_W] = rbyte;
		end
	end

	// Read mux; data stand only in the cycle after the strobe
	always_comb begin
		nxt_rdata = RD_UNMAPPED;
		if (I_RD && sel_four) begin
			nxt_rdata = word_four;
		end else if (I_RD && sel_five) begin
			nxt_rdata = word_five;
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST) begin
			rdata_ff <= RD_UNMAPPED;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	// Registered copies of the configuration, so every output leaves a flip-flop
	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST) begin
			on_ff   <= '0;
			msel_ff <= '0;
			fsel_ff <= '0;
		end else begin
			on_ff   <= cfg.on;
			msel_ff <= cfg.msel;
			fsel_ff <= cfg.fsel;
		end
	end

	// Routing: lowest-numbered enabled filter that reports a hit wins; hits of disabled filters are dropped
	always_comb begin
		nxt_route_valid = 1'b0;
		nxt_route_fifo  = '0;
		for (int j = NUM_FILT - 1; j >= 0; j--) begin
			if (I_HIT[j] && cfg.on[j]) begin
				nxt_route_valid = 1'b1;
				nxt_route_fifo  = cfg.fsel[j*FSEL_W +: FSEL_W];
			end
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST) begin
			route_valid_ff <= 1'b0;
			route_fifo_ff  <= '0;
		end else begin
			route_valid_ff <= nxt_route_valid;
			route_fifo_ff  <= nxt_route_fifo;
		end
	end

	assign O_RDATA       = rdata_ff;
	assign O_FILT_ON     = on_ff;
	assign O_MASK_PICK   = msel_ff;
	assign O_FIFO_DEST   = fsel_ff;
	assign O_ROUTE_VALID = route_valid_ff;
	assign O_ROUTE_FIFO  = route_fifo_ff;
endmodule : cafr_top
`default_nettype wire

// ==== test/cafr_checker.sv ====
// Checker: bus and routing assertions on the top ports
`timescale 1ns/1ns
`default_nettype none
module cafr_checker (
	input wire logic        I_CLOCK,
	input wire logic        I_SYS_RST,
	input wire logic [3:0]  I_ADDR,
	input wire logic [31:0] I_WDATA,
	input wire logic        I_WR,
	input wire logic        I_RD,
	input wire logic [7:0]  I_HIT,
	input wire logic [31:0] O_RDATA,
	input wire logic [7:0]  O_FILT_ON,
	input wire logic [15:0] O_MASK_PICK,
	input wire logic [39:0] O_FIFO_DEST,
	input wire logic        O_ROUTE_VALID,
	input wire logic [4:0]  O_ROUTE_FIFO
);
	default clocking @(posedge I_CLOCK); endclocking
	default disable iff (I_SYS_RST);
	// Outputs lag by one, so a write in the cycle before hides the stored enable
	sequence wr_four; I_WR && I_ADDR == 4'h0 && !$past(I_WR && I_ADDR == 4'h0); endsequence
	sequence wr_five; I_WR && I_ADDR == 4'h4 && !$past(I_WR && I_ADDR == 4'h4); endsequence
	rd_idle_a: assert property (!$past(I_RD) |-> O_RDATA == 32'h0) else $error("read data not idle");
	on_four_a: assert property (wr_four |-> ##2 O_FILT_ON[0] == $past(I_WDATA[7], 2))
		else $error("enable of first word wrong");
	on_five_a: assert property (wr_five |-> ##2 O_FILT_ON[7] == $past(I_WDATA[31], 2))
		else $error("enable of second word wrong");
	lock_four_a: assert property (wr_four ##0 O_FILT_ON[0] |-> ##2 $stable({O_MASK_PICK[1:0], O_FIFO_DEST[4:0]}))
		else $error("locked fields changed");
	upd_four_a: assert property (wr_four ##0 !O_FILT_ON[1] |-> ##2 O_MASK_PICK[3:2] == $past(I_WDATA[14:13], 2))
		else $error("mask select not written");
	upd_five_a: assert property (wr_five ##0 !O_FILT_ON[6] |-> ##2 O_FIFO_DEST[34:30] == $past(I_WDATA[20:16], 2))
		else $error("destination not written");
	route_cause_a: assert property (O_ROUTE_VALID |-> $past(|I_HIT)) else $error("route without hit");
	route_idle_a: assert property (!O_ROUTE_VALID |-> O_ROUTE_FIFO == 5'h0) else $error("idle route not zero");
endmodule : cafr_checker
bind cafr_top cafr_checker u_chk (.I_CLOCK, .I_SYS_RST, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .I_HIT, .O_RDATA,
	.O_FILT_ON, .O_MASK_PICK, .O_FIFO_DEST, .O_ROUTE_VALID, .O_ROUTE_FIFO);
`default_nettype wire

// ==== test/tb_cafr_top.sv ====
// Testbench: reset values, field layout, write lock and routing
`timescale 1ns/1ns
`default_nettype none
module tb_cafr_top;
	import cafr_pkg::*;
	logic        I_CLOCK, I_SYS_RST, I_WR, I_RD, O_ROUTE_VALID;
	logic [3:0]  I_ADDR;
	logic [31:0] I_WDATA, O_RDATA, rq;
	logic [7:0]  I_HIT, O_FILT_ON;
	logic [15:0] O_MASK_PICK;
	logic [39:0] O_FIFO_DEST;
	logic [4:0]  O_ROUTE_FIFO;
	int          miscompares, total_checks, cycles;
	cafr_top DUT (.I_CLOCK, .I_SYS_RST, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .I_HIT, .O_RDATA,
		.O_FILT_ON, .O_MASK_PICK, .O_FIFO_DEST, .O_ROUTE_VALID, .O_ROUTE_FIFO);
	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge I_CLOCK);
		I_WR <= 1'b1;
		I_ADDR <= a;
		I_WDATA <= d;
		@(posedge I_CLOCK);
		I_WR <= 1'b0;
	endtask : wr
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a);
		@(posedge I_CLOCK);
		I_RD <= 1'b1;
		I_ADDR <= a;
		@(posedge I_CLOCK);
		I_RD <= 1'b0;
		#1 rq = O_RDATA;
	endtask : rd
	// Route answer lands one cycle after the sampled hit
	task automatic hit(input logic [7:0] h, input logic [5:0] exp);
		@(posedge I_CLOCK);
		I_HIT <= h;
		@(posedge I_CLOCK);
		I_HIT <= 8'h00;
		#1 check({O_ROUTE_VALID, O_ROUTE_FIFO}, exp);
	endtask : hit
	task automatic complete_run;
		$display("checks %0d, mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : complete_run
	initial begin
		I_CLOCK = 1'b0;
		forever #5 I_CLOCK = ~I_CLOCK;
	end
	// Hang guard well beyond the roughly sixty cycles of the sequence
	always @(posedge I_CLOCK) begin
		cycles++;
		if (cycles == 2000) begin
			miscompares++;
			complete_run();
		end
	end
	initial begin
		{I_WR, I_RD, I_ADDR, I_WDATA, I_HIT} = '0;
		I_SYS_RST = 1'b1;
		repeat (8) @(posedge I_CLOCK);
		I_SYS_RST <= 1'b0;
		rd(4'h4);
		check(rq, 32'h0);
		wr(4'h0, 32'h75604a3f);
		wr(4'h8, 32'hffffffff);
		rd(4'h0);
		check(rq, 32'h75604a3f);
		check({O_MASK_PICK[3:0], O_FIFO_DEST[9:0]}, 14'h255f);
		rd(4'h8);
		check(rq, 32'h0);
		for (int i = 0; i < 4; i++) begin
			wr(4'h4, 32'(i) << 21);
			@(posedge I_CLOCK);
			#1 check(O_MASK_PICK[13:12], i);
		end
		wr(4'h4, 32'hb5000000);
		wr(4'h4, 32'h9f000000);
		rd(4'h4);
		check(rq, 32'hb5000000);
		wr(4'h4, 32'h1f000000);
		rd(4'h4);
		check(rq, 32'h35000000);
		wr(4'h4, 32'h1f000000);
		rd(4'h4);
		check({rq, O_FIFO_DEST[39:35]}, {32'h1f000000, 5'h1f});
		wr(4'h0, 32'h00008385);
		hit(8'h03, 6'h25);
		hit(8'h02, 6'h23);
		hit(8'h10, 6'h00);
		// Clearing write to live filters 16 and 17 drops the enables but keeps their fields
		wr(4'h0, 32'h0000001f);
		rd(4'h0);
		check(rq, 32'h00000305);
		hit(8'h01, 6'h00);
		complete_run();
	end
endmodule : tb_cafr_top
`default_nettype wire
